// [lcd_drive_defs.vh]
// Purpose: Shared constants for the passive LCD segment and common driver.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes: Definitions only; included by the driver and by its display memory.
`ifndef LCD_DRIVE_DEFS_VH
`define LCD_DRIVE_DEFS_VH

// ----------------------------------------------------------------
// Register map (word indices).
// ----------------------------------------------------------------
`define IDX_SEG_PIN_ENABLE 8'h38
`define IDX_DISPLAY_MODE 8'h39
`define IDX_RAM_FIRST 8'h40
`define IDX_RAM_LAST 8'h53
`define RAM_DEPTH 20
`define RAM_AW 5

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define RST_SEG_PIN_ENABLE 8'h00
`define RST_DISPLAY_MODE 8'h00

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define SPE_GROUP_LSB 0
`define SPE_GROUP_MSB 5
`define SPE_OUT_EN 6
`define DM_DUTY_LSB 0
`define DM_DUTY_MSB 1
`define DM_BIAS_HALF 2
`define DM_DISP_EN 3
`define DM_MULT_EN 4
`define DM_DIV_LSB 5
`define DM_DIV_MSB 6
`define DM_SRC_SEL 7

// ----------------------------------------------------------------
// Duty codes and drive level codes.
// ----------------------------------------------------------------
`define DUTY_RESERVED 2'h0
`define LVL_V0 2'h0
`define LVL_1 2'h1
`define LVL_2 2'h2
`define LVL_3 2'h3

// ----------------------------------------------------------------
// Panel geometry.
// ----------------------------------------------------------------
`define NUM_SEG 40
`define NUM_COM 4
`define FIRST_SHARED_SEG 18
`define SEGS_PER_GROUP 4
`define NUM_SHARED_SEG 22

`endif

// [lcd_display_ram.v]
// Purpose: Twenty-byte display memory with registered bus read and scan column read.
// Assumes: One write port from the bus slave; all reads are registered.
// Notes: The column output gathers one common's bit of every segment at once.
`include "lcd_drive_defs.vh"

module lcd_display_ram (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Bus side.
  input wire wrEn,
  input wire [4:0] addr,
  input wire [7:0] wrData,
  output reg [7:0] rdData_ff,
  // Scan side.
  input wire [1:0] colSel,
  output reg [39:0] colBits_ff
);

  reg [7:0] mem [0:`RAM_DEPTH-1];
  integer k;

  // ----------------------------------------------------------------
  // Storage and registered reads.
  // ----------------------------------------------------------------
  // Contents are not cleared by reset; software fills the memory first.
  always @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    if (!rst_b) begin
      rdData_ff <= 8'h00;
      colBits_ff <= 40'h0000000000;
    end else begin
      rdData_ff <= mem[addr];
      for (k = 0; k < `RAM_DEPTH; k = k + 1) begin
        colBits_ff[2*k] <= mem[k][colSel]; // Low nibble is the even segment
        colBits_ff[2*k+1] <= mem[k][4+colSel]; // High nibble is the odd segment
      end
    end
  end

endmodule // lcd_display_ram

// [lcd_segment_common_driver.v]
// Purpose: Multiplexed passive LCD driver with Wishbone register access.
// Assumes: countSrcA and countSrcB are slow count-source levels from outside this clock domain.
// Notes: Pin levels are two-bit codes 0 = ground, 1 = low, 2 = mid, 3 = top drive level.
//
// Function
// - Setting display enable with duty code 01, 10 or 11 starts autonomous fetch, bias and duty drive.
// - Up to forty segment lines and four common lines, 160 pixels.
// - Pixels addressable: 80 at duty 2, 120 at duty 3, 160 at duty 4.
// - Mode bits 1:0 pick duty; 01, 10, 11 use two, three, four commons.
// - Commons not used at the chosen duty are left open.
// - Mode bit 2 selects half bias or third bias drive levels.
// - While output enable is clear, top level input is tied to core supply.
// - After reset every common line drives the top level.
// - Segments 0-17 dedicated, 18-25 output-port shared, 26-39 bidirectional shared.
// - After reset dedicated segments drive top; shared ones float with pull-up.
// - Display memory is twenty bytes; a stored one turns the pixel on.
// - Low nibble even segment, high nibble odd segment, bit n is common n.
// - Drive clock is count source over divider; frame is drive clock over duty.
// - Mode bits 6:5 select divider ratio, bit 7 selects count source.
//
// Implementation choices: the Wishbone register port and the register addresses.
`include "lcd_drive_defs.vh"

module lcd_segment_common_driver (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Wishbone classic slave.
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o_ff,
  output reg ack_o_ff,
  // Count sources for the drive clock.
  input wire countSrcA,
  input wire countSrcB,
  // Panel lines.
  output reg [7:0] commonLevel_ff,
  output reg [3:0] commonDrive_ff,
  output reg [79:0] segmentLevel_ff,
  output reg [39:0] segmentDrive_ff,
  output reg [21:0] segmentPullUp_ff,
  // Supply control.
  output reg topTiedToCore_ff,
  output reg multiplierOn_ff,
  output reg biasHalf_ff,
  output reg panelDriveClock_ff
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  reg [7:0] segPinEnable_ff;
  reg [7:0] displayMode_ff;
  reg reqSeen_ff;
  reg srcASync1_ff, srcASync2_ff, srcAPrev_ff;
  reg srcBSync1_ff, srcBSync2_ff, srcBPrev_ff;
  reg [2:0] divCnt_ff;
  reg [1:0] comSel_ff;
  reg [1:0] comSelD_ff;
  reg frame_ff;
  reg frameD_ff;
  reg [2:0] divMax;
  reg [7:0] nxt_dat;
  wire [7:0] regIdx;
  wire isRam;
  wire wrNow;
  wire [4:0] ramAddr;
  wire [7:0] ramOff;
  wire [7:0] ramRd;
  wire [39:0] colBits;
  wire [1:0] duty;
  wire scanOn;
  wire outEn;
  wire srcTick;
  wire driveTick;
  integer i;

  assign regIdx = adr_i[9:2];
  assign isRam = (regIdx >= `IDX_RAM_FIRST) && (regIdx <= `IDX_RAM_LAST);
  assign ramOff = regIdx - `IDX_RAM_FIRST;
  assign ramAddr = ramOff[4:0]; // Only twenty cells exist, so five bits cover the offset.
  assign duty = displayMode_ff[`DM_DUTY_MSB:`DM_DUTY_LSB];
  assign outEn = segPinEnable_ff[`SPE_OUT_EN];
  // The scan runs only with display enabled and a defined duty code.
  assign scanOn = displayMode_ff[`DM_DISP_EN] && (duty != `DUTY_RESERVED);

  // ----------------------------------------------------------------
  // Wishbone slave.
  // ----------------------------------------------------------------
  // A request is seen on the first edge and answered on the second, which gives the
  // display memory its registered read cycle; unmapped indices read zero and ignore writes.
  assign wrNow = reqSeen_ff && !ack_o_ff && cyc_i && stb_i && we_i && sel_i[0];

  always @* begin
    nxt_dat = 8'h00;
    if (isRam) begin
      nxt_dat = ramRd;
    end else if (regIdx == `IDX_SEG_PIN_ENABLE) begin
      nxt_dat = segPinEnable_ff;
    end else if (regIdx == `IDX_DISPLAY_MODE) begin
      nxt_dat = displayMode_ff;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      reqSeen_ff <= 1'b0;
      ack_o_ff <= 1'b0;
      dat_o_ff <= 32'h00000000;
      segPinEnable_ff <= `RST_SEG_PIN_ENABLE;
      displayMode_ff <= `RST_DISPLAY_MODE;
    end else begin
      if (ack_o_ff) begin
        ack_o_ff <= 1'b0;
        reqSeen_ff <= 1'b0;
      end else if (reqSeen_ff) begin
        ack_o_ff <= 1'b1;
        dat_o_ff <= {24'h000000, nxt_dat};
      end else if (cyc_i && stb_i) begin
        reqSeen_ff <= 1'b1;
      end
      if (wrNow && (regIdx == `IDX_SEG_PIN_ENABLE)) begin
        segPinEnable_ff <= {1'b0, dat_i[6:0]};
      end
      if (wrNow && (regIdx == `IDX_DISPLAY_MODE)) begin
        displayMode_ff <= dat_i[7:0];
      end
    end
  end

  // Display memory; a one stored in a cell lights its pixel.
  lcd_display_ram u_ram (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrNow && isRam),
    .addr(ramAddr),
    .wrData(dat_i[7:0]),
    .rdData_ff(ramRd),
    .colSel(comSel_ff),
    .colBits_ff(colBits)
  );

  // ----------------------------------------------------------------
  // Count source and drive clock divider.
  // ----------------------------------------------------------------
  // Both sources are synchronised; edges are taken only between the second and third flop.
  always @(posedge clk) begin
    if (!rst_b) begin
      srcASync1_ff <= 1'b0;
      srcASync2_ff <= 1'b0;
      srcAPrev_ff <= 1'b0;
      srcBSync1_ff <= 1'b0;
      srcBSync2_ff <= 1'b0;
      srcBPrev_ff <= 1'b0;
    end else begin
      srcASync1_ff <= countSrcA;
      srcASync2_ff <= srcASync1_ff;
      srcAPrev_ff <= srcASync2_ff;
      srcBSync1_ff <= countSrcB;
      srcBSync2_ff <= srcBSync1_ff;
      srcBPrev_ff <= srcBSync2_ff;
    end
  end

  // Mode bit 7 picks the source, bits 6:5 the ratio 1, 2, 4 or 8.
  assign srcTick = displayMode_ff[`DM_SRC_SEL] ? (srcBSync2_ff && !srcBPrev_ff)
                                               : (srcASync2_ff && !srcAPrev_ff);

  always @* begin
    case (displayMode_ff[`DM_DIV_MSB:`DM_DIV_LSB])
      2'h0: divMax = 3'h0;
      2'h1: divMax = 3'h1;
      2'h2: divMax = 3'h3;
      2'h3: divMax = 3'h7;
      default: divMax = 3'h0;
    endcase
  end

  // Gated by the scan so that a stopped or reserved display also stops the drive clock pulses.
  assign driveTick = scanOn && srcTick && (divCnt_ff >= divMax);

  // ----------------------------------------------------------------
  // Common scan and frame polarity.
  // ----------------------------------------------------------------
  // One common per drive slot; after the last used common the polarity flips, so each
  // frame lasts duty drive slots and the panel sees no net DC over two frames.
  always @(posedge clk) begin
    if (!rst_b) begin
      divCnt_ff <= 3'h0;
      comSel_ff <= 2'h0;
      frame_ff <= 1'b0;
      comSelD_ff <= 2'h0;
      frameD_ff <= 1'b0;
      panelDriveClock_ff <= 1'b0;
    end else begin
      panelDriveClock_ff <= driveTick;
      if (!scanOn) begin
        divCnt_ff <= 3'h0;
        comSel_ff <= 2'h0;
        frame_ff <= 1'b0;
      end else if (driveTick) begin
        divCnt_ff <= 3'h0;
        if (comSel_ff >= duty) begin
          comSel_ff <= 2'h0;
          frame_ff <= !frame_ff;
        end else begin
          comSel_ff <= comSel_ff + 2'h1;
        end
      end else if (srcTick) begin
        divCnt_ff <= divCnt_ff + 3'h1;
      end
      // Delay by one so the scan state lines up with the registered column read.
      comSelD_ff <= comSel_ff;
      frameD_ff <= frame_ff;
    end
  end

  // ----------------------------------------------------------------
  // Level selection helpers.
  // ----------------------------------------------------------------
  // Selected common swings to an extreme; others sit at a middle level.
  function [1:0] comLvl;
    input sel;
    input frame;
    input half;
    begin
      if (sel) begin
        comLvl = frame ? `LVL_V0 : `LVL_3;
      end else if (half) begin
        comLvl = `LVL_1; // Under half bias the two middle levels are one.
      end else begin
        comLvl = frame ? `LVL_2 : `LVL_1;
      end
    end
  endfunction

  // An on segment takes the extreme opposite the selected common.
  function [1:0] segLvl;
    input on;
    input frame;
    input half;
    begin
      if (on) begin
        segLvl = frame ? `LVL_3 : `LVL_V0;
      end else if (half) begin
        segLvl = frame ? `LVL_V0 : `LVL_3;
      end else begin
        segLvl = frame ? `LVL_1 : `LVL_2;
      end
    end
  endfunction

  // Shared segments are grouped four to an enable bit, starting at segment 18.
  function groupOn;
    input integer seg;
    input [5:0] en;
    begin
      if (seg < `FIRST_SHARED_SEG) begin
        groupOn = 1'b1;
      end else begin
        groupOn = en[(seg - `FIRST_SHARED_SEG) / `SEGS_PER_GROUP];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin drivers.
  // ----------------------------------------------------------------
  // Outside the scan every common and every driven segment rests at the top level, which
  // is also the reset picture; shared pins stay with their port until enabled.
  always @(posedge clk) begin
    if (!rst_b) begin
      commonLevel_ff <= {`NUM_COM{`LVL_3}};
      commonDrive_ff <= 4'hf;
      segmentLevel_ff <= {`NUM_SEG{`LVL_3}};
      segmentDrive_ff <= 40'h000003ffff; // Dedicated lines driven, shared floating
      segmentPullUp_ff <= 22'h3fffff;
      topTiedToCore_ff <= 1'b1;
      multiplierOn_ff <= 1'b0;
      biasHalf_ff <= 1'b0;
    end else begin
      topTiedToCore_ff <= !outEn;
      multiplierOn_ff <= outEn && displayMode_ff[`DM_MULT_EN];
      biasHalf_ff <= displayMode_ff[`DM_BIAS_HALF];
      for (i = 0; i < `NUM_COM; i = i + 1) begin
        if (!scanOn) begin
          commonLevel_ff[2*i +: 2] <= `LVL_3;
          commonDrive_ff[i] <= 1'b1;
        end else begin
          commonLevel_ff[2*i +: 2] <= comLvl(comSelD_ff == i, frameD_ff,
                                             displayMode_ff[`DM_BIAS_HALF]);
          commonDrive_ff[i] <= (i <= duty); // Unused commons open
        end
      end
      for (i = 0; i < `NUM_SEG; i = i + 1) begin
        segmentDrive_ff[i] <= groupOn(i, segPinEnable_ff[`SPE_GROUP_MSB:`SPE_GROUP_LSB]);
        if (!scanOn) begin
          segmentLevel_ff[2*i +: 2] <= `LVL_3;
        end else begin
          segmentLevel_ff[2*i +: 2] <= segLvl(colBits[i], frameD_ff,
                                              displayMode_ff[`DM_BIAS_HALF]);
        end
      end
      for (i = 0; i < `NUM_SHARED_SEG; i = i + 1) begin
        segmentPullUp_ff[i] <= !groupOn(i + `FIRST_SHARED_SEG,
                                        segPinEnable_ff[`SPE_GROUP_MSB:`SPE_GROUP_LSB]);
      end
    end
  end

endmodule // lcd_segment_common_driver

// [lcd_driver_props.sv]
// Purpose: Bus and pin checks for the LCD segment and common driver.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Sees only the driver's ports; attached by the bind at the foot.
module lcd_driver_props (
  // Clock and reset.
  input logic clk,
  input logic rst_b,
  // Register bus.
  input logic cyc_i,
  input logic stb_i,
  input logic ack_o_ff,
  // Panel lines and supply control.
  input logic [7:0] commonLevel_ff,
  input logic [3:0] commonDrive_ff,
  input logic [39:0] segmentDrive_ff,
  input logic [21:0] segmentPullUp_ff,
  input logic topTiedToCore_ff,
  input logic multiplierOn_ff,
  input logic biasHalf_ff,
  input logic panelDriveClock_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Count driven commons at ground and spot any at the mid level.
  logic [2:0] zeroCnt;
  logic midSeen;
  always_comb begin
    zeroCnt = 3'h0;
    midSeen = 1'b0;
    for (int n = 0; n < 4; n++) begin
      if (commonDrive_ff[n] && commonLevel_ff[2*n+:2] == 2'h0) zeroCnt = zeroCnt + 3'h1;
      if (commonDrive_ff[n] && commonLevel_ff[2*n+:2] == 2'h2) midSeen = 1'b1;
    end
  end
  // --------------------------------
  // Assertions.
  // --------------------------------
  ack_pulse_a: assert property (ack_o_ff |=> !ack_o_ff) else $error("ack held too long");
  ack_latency_a: assert property ($rose(cyc_i && stb_i) |-> !ack_o_ff ##1 !ack_o_ff ##1 ack_o_ff)
    else $error("ack latency wrong");
  reset_commons_a: assert property ($rose(rst_b) |-> commonLevel_ff == 8'hff && commonDrive_ff == 4'hf)
    else $error("commons not top after reset");
  reset_segs_a: assert property ($rose(rst_b) |-> segmentPullUp_ff == 22'h3fffff && topTiedToCore_ff)
    else $error("segments wrong after reset");
  dedicated_seg_a: assert property (segmentDrive_ff[17:0] == 18'h3ffff) else $error("dedicated idle");
  shared_pull_a: assert property ((segmentPullUp_ff ^ segmentDrive_ff[39:18]) == 22'h3fffff)
    else $error("pull-up and drive clash");
  common_mask_a: assert property (commonDrive_ff inside {4'h3, 4'h7, 4'hf}) else $error("bad commons");
  one_selected_a: assert property (zeroCnt <= 3'h1) else $error("two commons selected");
  tick_pulse_a: assert property (panelDriveClock_ff |=> !panelDriveClock_ff) else $error("tick too long");
  half_bias_a: assert property (biasHalf_ff && $past(biasHalf_ff, 4) |-> !midSeen)
    else $error("mid level at half bias");
  mult_oe_a: assert property (multiplierOn_ff |-> !topTiedToCore_ff) else $error("multiplier while tied");
  // Main scenarios.
  scan_four_c: cover property (commonDrive_ff == 4'hf && zeroCnt == 3'h1);
  tick_c: cover property (panelDriveClock_ff);
  ack_c: cover property (ack_o_ff);
endmodule // lcd_driver_props

bind lcd_segment_common_driver lcd_driver_props i_lcd_driver_props (.clk(clk), .rst_b(rst_b), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o_ff(ack_o_ff), .commonLevel_ff(commonLevel_ff), .commonDrive_ff(commonDrive_ff),
  .segmentDrive_ff(segmentDrive_ff), .segmentPullUp_ff(segmentPullUp_ff), .topTiedToCore_ff(topTiedToCore_ff),
  .multiplierOn_ff(multiplierOn_ff), .biasHalf_ff(biasHalf_ff), .panelDriveClock_ff(panelDriveClock_ff));

// [lcd_panel_model.sv]
// Purpose: Passive glass that reports the selected common and its lit pixels.
// Assumes: Level codes 0 to 3; a pixel lights only at the full level swing.
// Notes: Under static all-top drive nothing is lit.
module lcd_panel_model (
  // Electrode levels from the driver.
  input logic [7:0] commonLevel,
  input logic [3:0] commonDrive,
  input logic [79:0] segmentLevel,
  input logic [39:0] segmentDrive,
  // What the glass shows.
  output logic [1:0] selCom,
  output logic selHigh,
  output logic [39:0] litRow
);
  // The selected common sits at an outer level, the others between.
  always_comb begin
    selCom = 2'h0;
    for (int n = 0; n < 4; n++) begin
      if (commonDrive[n] && commonLevel[2*n+:2] inside {2'h0, 2'h3}) selCom = n[1:0];
    end
    selHigh = commonLevel[2*selCom+:2] == 2'h3;
    for (int s = 0; s < 40; s++) begin
      litRow[s] = segmentDrive[s] && (segmentLevel[2*s+:2] ^ commonLevel[2*selCom+:2]) == 2'h3;
    end
  end
endmodule // lcd_panel_model

// [lcd_segment_common_driver_tb_top.sv]
// Purpose: Self-checking bench for the LCD segment and common driver.
// Assumes: Count sources are square waves of 8 and 16 clocks.
// Notes: The glass model tells which common is selected and what is lit.
`include "lcd_drive_defs.vh"
module lcd_segment_common_driver_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic countSrcA = 1'b0;
  logic countSrcB = 1'b0;
  logic [3:0] srcCnt = 4'h0;
  logic [31:0] dat_o_ff;
  logic ack_o_ff, topTiedToCore_ff, multiplierOn_ff, biasHalf_ff, panelDriveClock_ff, selHigh;
  logic [7:0] commonLevel_ff, rdVal;
  logic [3:0] commonDrive_ff;
  logic [79:0] segmentLevel_ff;
  logic [39:0] segmentDrive_ff, litRow;
  logic [21:0] segmentPullUp_ff;
  logic [1:0] selCom;
  logic [7:0] ramExp [20];
  int failures = 0;
  int tests_run = 0;
  int pc;
  lcd_segment_common_driver i_lcd_segment_common_driver (.clk(clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o_ff(dat_o_ff), .ack_o_ff(ack_o_ff),
    .countSrcA(countSrcA), .countSrcB(countSrcB), .commonLevel_ff(commonLevel_ff), .commonDrive_ff(commonDrive_ff),
    .segmentLevel_ff(segmentLevel_ff), .segmentDrive_ff(segmentDrive_ff), .segmentPullUp_ff(segmentPullUp_ff),
    .topTiedToCore_ff(topTiedToCore_ff), .multiplierOn_ff(multiplierOn_ff), .biasHalf_ff(biasHalf_ff),
    .panelDriveClock_ff(panelDriveClock_ff));
  lcd_panel_model i_lcd_panel_model (.commonLevel(commonLevel_ff), .commonDrive(commonDrive_ff),
    .segmentLevel(segmentLevel_ff), .segmentDrive(segmentDrive_ff), .selCom(selCom), .selHigh(selHigh),
    .litRow(litRow));
  // --------------------------------
  // Clock, count sources and tasks.
  // --------------------------------
  always #12.5 clk = ~clk;
  // Sources are made from the clock so that slot lengths come out exact.
  always @(posedge clk) begin
    srcCnt <= srcCnt + 4'h1;
    countSrcA <= srcCnt[2];
    countSrcB <= srcCnt[3];
  end
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o_ff !== 1'b1 && n < 20);
    rdVal = dat_o_ff[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) failures++;
  endtask
  task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 4'h1, 8'h0);
    check(what, rdVal, exp);
  endtask
  task automatic waitTick;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (panelDriveClock_ff !== 1'b1 && n < 600);
    if (n >= 600) failures++;
  endtask
  function automatic logic [39:0] expRow(input logic [1:0] c);
    for (int s = 0; s < 40; s++) expRow[s] = ramExp[s / 2][4 * (s % 2) + c];
  endfunction
  // Each pass starts from a stopped display so old levels do not linger.
  task automatic scanPass(input logic [1:0] duty, input logic half);
    logic [1:0] prev;
    logic pol;
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, 8'h00);
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, {5'h01, half, duty});
    @(posedge clk); // The flag follows the mode register one edge after the write.
    check("bias flag", biasHalf_ff, half);
    for (int k = 0; k < 2 * duty + 3; k++) begin
      waitTick();
      repeat (3) @(posedge clk);
      check("common drive", commonDrive_ff, (4'h2 << duty) - 4'h1);
      check("lit pixels", litRow, expRow(selCom));
      if (k > 0) check("common order", selCom, prev == duty ? 2'h0 : prev + 2'h1);
      if (k > 0) check("polarity", selHigh, selCom == 2'h0 ? !pol : pol);
      prev = selCom;
      pol = selHigh;
    end
  endtask
  task automatic gapChk(input logic [7:0] mode, input int gap);
    int g;
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, 8'h00);
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, mode);
    waitTick();
    waitTick();
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (panelDriveClock_ff !== 1'b1 && g < 300);
    check("slot length", g, gap);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("common levels", commonLevel_ff, 8'hff);
    check("common drive", commonDrive_ff, 4'hf);
    check("segment levels", segmentLevel_ff, {80{1'b1}});
    check("segment drive", segmentDrive_ff, 40'h3ffff);
    check("top tie", topTiedToCore_ff, 1'b1);
    check("pull-ups", segmentPullUp_ff, 22'h3fffff);
    rdChk("mode reset", `IDX_DISPLAY_MODE, 8'h00);
    $display("test reset done");
    wb(1'b1, `IDX_SEG_PIN_ENABLE, 4'h1, 8'hbf);
    rdChk("enable top bit", `IDX_SEG_PIN_ENABLE, 8'h3f);
    check("shared drive", segmentDrive_ff, {40{1'b1}});
    check("tie kept", topTiedToCore_ff, 1'b1);
    check("pull-ups off", segmentPullUp_ff, 22'h000000);
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h0, 8'h55);
    rdChk("masked write", `IDX_DISPLAY_MODE, 8'h00);
    wb(1'b1, 8'h3a, 4'h1, 8'h77);
    rdChk("unmapped", 8'h3a, 8'h00);
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, 8'h03);
    wb(1'b1, `IDX_SEG_PIN_ENABLE, 4'h1, 8'h7f);
    repeat (2) @(posedge clk);
    check("tie released", topTiedToCore_ff, 1'b0);
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, 8'h13);
    rdChk("mode readback", `IDX_DISPLAY_MODE, 8'h13);
    check("multiplier", multiplierOn_ff, 1'b1);
    $display("test registers done");
    for (int k = 0; k < `RAM_DEPTH; k++) begin
      ramExp[k] = 8'h35 + 8'h1d * k[7:0];
      wb(1'b1, `IDX_RAM_FIRST + k[7:0], 4'h1, ramExp[k]);
    end
    for (int k = 0; k < `RAM_DEPTH; k++) rdChk("display byte", `IDX_RAM_FIRST + k[7:0], ramExp[k]);
    rdChk("past display", 8'h54, 8'h00);
    $display("test memory done");
    for (int b = 0; b < 2; b++) for (int d = 1; d < 4; d++) scanPass(d[1:0], b[0]);
    $display("test scan done");
    wb(1'b1, `IDX_DISPLAY_MODE, 4'h1, 8'h08);
    pc = 0;
    repeat (100) begin
      @(posedge clk);
      if (panelDriveClock_ff !== 1'b0) pc++;
    end
    check("reserved ticks", pc, 0);
    check("reserved commons", commonLevel_ff, 8'hff);
    check("reserved segments", segmentLevel_ff, {80{1'b1}});
    $display("test reserved duty done");
    for (int r = 0; r < 4; r++) gapChk({1'b0, r[1:0], 5'h0b}, 8 << r);
    gapChk(8'hab, 32);
    $display("test divider done");
    report_and_stop();
  end
  // Watchdog well beyond the thousand or so cycles the tests need.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // lcd_segment_common_driver_tb_top
